// ===== hdl/adr_pkg.sv
// adr_pkg: constants and types of the amplifier diagnostic report block
// Assumes a 40 MHz reference clock and a byte link clocked by the host
// Behaviour
// - With several faults present, at least one is in the second read
// - Remaining faults show on later reads as earlier ones are removed
// - A short with the speaker open is reported as the short alone
// - Permanent cycles never flag open load; only turn-on cycles do
// - A fault is reported only if present for the whole measurement
// - Any read re-arms turn-on, permanent and offset cycles
// - A read returns the previous cycle, so changes need two reads
// - Three thermal warnings are carried in the diagnostic bytes
// - Fast mute bit set makes mute transitions finish under 1.5 ms
// - Paired channels join while power is low, split when it rises
// - Low supply suspends joining; it resumes with the kept setting
// - Open address pin disables the bus; standby/mute comes from pin
// - Bus off: efficiency pin picks mode, data pin picks gain
// - Address pin resistor range selects one of three addresses
// - Address bit 0 low writes instructions, high reads diagnostics
// - First instruction bit 6 enables diagnostics, clear defeats
// - First instruction bit 5 enables offset test and starts window
// - Second instruction bit 4 low holds standby, high lets it run
package adr_pkg;
  // ------------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------------
  localparam int NCH           = 4;
  localparam int NTW           = 3;
  localparam int REF_HZ        = 40_000_000;
  localparam int MEAS_MS       = 100;
  localparam int MEAS_CYC_DEF  = REF_HZ / 1000 * MEAS_MS;
  localparam int FMUTE_US      = 1500;
  localparam int FMUTE_CYC_DEF = REF_HZ / 1_000_000 * FMUTE_US - 1;
  localparam int NMUTE_MS      = 20;
  localparam int NMUTE_CYC_DEF = REF_HZ / 1000 * NMUTE_MS;
  // ------------------------------------------------------------------
  // Addresses and address pin codes
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_A     = 7'h6C;
  localparam logic [6:0] ADDR_B     = 7'h6D;
  localparam logic [6:0] ADDR_C     = 7'h6E;
  localparam logic [1:0] ADSEL_GND  = 2'h0;
  localparam logic [1:0] ADSEL_MID  = 2'h1;
  localparam logic [1:0] ADSEL_OPEN = 2'h3;
  // ------------------------------------------------------------------
  // Instruction and diagnostic byte fields
  // ------------------------------------------------------------------
  localparam int FIB_SUPTH = 7;
  localparam int FIB_DIAG  = 6;
  localparam int FIB_OFFS  = 5;
  localparam int FIB_GF    = 4;
  localparam int FIB_GR    = 3;
  localparam int FIB_UMF   = 2;
  localparam int FIB_UMR   = 1;
  localparam int FIB_CLIP  = 0;
  localparam int SIB_FAST  = 5;
  localparam int SIB_RUN   = 4;
  localparam int SIB_HE_R  = 1;
  localparam int SIB_HE_L  = 0;
  localparam int DB_TW     = 7;
  localparam int DB_DONE   = 6;
  localparam int DB_PERM   = 4;
  localparam int DB_ACR    = 3;
  localparam int DB_OPEN   = 2;
  localparam int DB_SVS    = 1;
  localparam int DB_SGND   = 0;
  localparam logic [7:0] IN_RST = 8'h00;
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {DG_IDLE = 2'h0, DG_MEAS = 2'h1, DG_DONE = 2'h3} adr_dg_t;
  typedef struct packed {
    logic offset;
    logic open_load;
    logic across;
    logic short_vs;
    logic short_gnd;
  } adr_fault_t;
  typedef logic [NCH-1:0][7:0] adr_diag_t;
  typedef struct packed {
    logic [3:0] bitc;
    logic [2:0] bytec;
    logic [7:0] sh;
    logic       match;
    logic       rd;
    logic [7:0] first;
    logic       oe;
  } adr_link_t;
  typedef struct packed {
    logic        wr_tgl;
    logic        rd_tgl;
    logic [15:0] wdat;
    logic        res_seen;
    adr_diag_t   rcopy;
  } adr_xfer_t;
  typedef struct packed {
    logic                   wseen;
    logic                   rseen;
    logic [7:0]             fib;
    logic [7:0]             sib;
    adr_dg_t                dg;
    logic [22:0]            tmr;
    logic                   perm;
    adr_fault_t [NCH-1:0]   acc;
    adr_diag_t              res;
    logic                   res_tgl;
    logic                   den;
    logic                   oen;
    logic [1:0]             mreq;
    logic [1:0]             mout;
    logic [19:0]            mcnt;
    logic                   stby;
    logic [1:0]             gain;
    logic [1:0]             pair;
    logic                   clip;
    logic                   supth;
    logic                   busdis;
  } adr_core_t;
endpackage

// ===== hdl/adr_sync.sv
// adr_sync: two-flop synchroniser for a vector of levels
// Assumes each bit changes slowly or is a toggle
module adr_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end
  assign o_q = s2_r;
endmodule

// ===== hdl/adr_core.sv
// adr_core: instruction intake, diagnostic latching and report, mute,
// efficiency and address handling of a four-channel amplifier
// Assumes analog detectors give per-channel fault levels, a link clock
// from the host framed by i_link_frame, and open-drain data resolved outside
module adr_core #(
  parameter int MEAS_CYC  = adr_pkg::MEAS_CYC_DEF,
  parameter int FMUTE_CYC = adr_pkg::FMUTE_CYC_DEF,
  parameter int NMUTE_CYC = adr_pkg::NMUTE_CYC_DEF
) (
  input  wire logic                                i_ref_clk,
  input  wire logic                                i_resetn,
  input  wire logic                                i_link_clk,
  input  wire logic                                i_link_frame,
  input  wire logic                                i_sda_in,
  output logic                                     o_sda_out,
  output logic                                     o_sda_oe,
  input  wire logic [1:0]                          i_adsel_code,
  input  wire logic [1:0]                          i_standby_mute_pin,
  input  wire logic                                i_efficiency_select_pin,
  input  wire logic                                i_data_pin,
  input  wire adr_pkg::adr_fault_t [adr_pkg::NCH-1:0] i_fault,
  input  wire logic [adr_pkg::NTW-1:0]             i_thermal_warn,
  input  wire logic                                i_supply_low,
  input  wire logic [1:0]                          i_low_power,
  output logic                                     o_standby,
  output logic                                     o_front_mute,
  output logic                                     o_rear_mute,
  output logic                                     o_mute_busy,
  output logic [1:0]                               o_gain_16db,
  output logic [1:0]                               o_bridge_join,
  output logic                                     o_clip_10pct,
  output logic                                     o_supply_thr_high,
  output logic                                     o_bus_disabled,
  output adr_pkg::adr_diag_t                       o_diag_result
);
  localparam int NCH = adr_pkg::NCH;
  localparam int SW  = 14 + 5 * NCH;
  adr_pkg::adr_core_t c_r;
  adr_pkg::adr_core_t c_nxt;
  adr_pkg::adr_link_t lk_r;
  adr_pkg::adr_link_t lk_nxt;
  adr_pkg::adr_xfer_t lx_r;
  adr_pkg::adr_xfer_t lx_nxt;

  // ----------------------------------------------------------------------
  // Link side: byte framing, address match, instruction and read slots
  // ----------------------------------------------------------------------
  logic [1:0] ls_adsel;
  logic       ls_res;
  logic       link_rstn;
  logic [7:0] byte_in;
  logic [6:0] addr_l;
  logic [2:0] rsel;

  // Address code and result toggle brought onto the link clock
  adr_sync #(.W(3)) u_lsync (
    .i_clk    (i_link_clk),
    .i_resetn (i_resetn),
    .i_d      ({i_adsel_code, c_r.res_tgl}),
    .o_q      ({ls_adsel, ls_res})
  );
  // Frame end clears the byte machine even with the link clock stopped
  assign link_rstn = i_resetn & i_link_frame;

  // Next link state per sampled bit
  always_comb begin
    lk_nxt  = lk_r;
    lx_nxt  = lx_r;
    byte_in = {lk_r.sh[6:0], i_sda_in};
    case (ls_adsel)
      adr_pkg::ADSEL_GND: addr_l = adr_pkg::ADDR_A;
      adr_pkg::ADSEL_MID: addr_l = adr_pkg::ADDR_B;
      default:            addr_l = adr_pkg::ADDR_C;
    endcase
    // Fresh result word, held stable by its toggle handshake
    if (ls_res != lx_r.res_seen) begin
      lx_nxt.res_seen = ls_res;
      lx_nxt.rcopy    = c_r.res;
    end
    if (lk_r.bitc == 4'h8) begin
      lk_nxt.bitc = 4'h0;
      if (lk_r.bytec != 3'h7) begin
        lk_nxt.bytec = lk_r.bytec + 3'h1;
      end
      if (lk_r.match && lk_r.rd && lk_r.bytec == 3'h4) begin
        lx_nxt.rd_tgl = ~lx_r.rd_tgl;
      end
    end else begin
      lk_nxt.bitc = lk_r.bitc + 4'h1;
      lk_nxt.sh   = byte_in;
      if (lk_r.bitc == 4'h7) begin
        if (lk_r.bytec == 3'h0) begin
          lk_nxt.match = (ls_adsel != adr_pkg::ADSEL_OPEN) && (byte_in[7:1] == addr_l);
          lk_nxt.rd    = byte_in[0];
        end else if (lk_r.match && !lk_r.rd) begin
          if (lk_r.bytec == 3'h1) begin
            lk_nxt.first = byte_in;
          end else if (lk_r.bytec == 3'h2) begin
            lx_nxt.wdat   = {lk_r.first, byte_in};
            lx_nxt.wr_tgl = ~lx_r.wr_tgl;
          end
        end
      end
    end
    // Drive low for the slot sampled at the next link edge
    rsel      = lk_nxt.bytec - 3'h1;
    lk_nxt.oe = 1'b0;
    if (lk_nxt.bitc == 4'h8) begin
      lk_nxt.oe = lk_nxt.match && (lk_nxt.bytec == 3'h0 || (!lk_nxt.rd && lk_nxt.bytec < 3'h3));
    end else if (lk_nxt.match && lk_nxt.rd && lk_nxt.bytec != 3'h0 && lk_nxt.bytec < 3'h5) begin
      lk_nxt.oe = ~lx_nxt.rcopy[rsel[1:0]][3'h7 - lk_nxt.bitc[2:0]];
    end
  end

  // Byte machine, cleared outside frames
  always_ff @(posedge i_link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // Handshake words, kept across frames
  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lx_r <= '0;
    end else begin
      lx_r <= lx_nxt;
    end
  end
  assign o_sda_out = 1'b0;
  assign o_sda_oe  = lk_r.oe;

  // ----------------------------------------------------------------------
  // Reference side: pins, instruction bytes, diagnostic cycles
  // ----------------------------------------------------------------------
  logic                           s_wr;
  logic                           s_rd;
  logic [1:0]                     s_adsel;
  logic [1:0]                     s_stby;
  logic                           s_eff;
  logic                           s_data;
  adr_pkg::adr_fault_t [NCH-1:0]  s_fault;
  logic [adr_pkg::NTW-1:0]        s_therm;
  logic                           s_slow;
  logic [1:0]                     s_lowp;
  logic                           rd_ev;
  logic                           busdis;
  logic                           run;
  logic [1:0]                     unm;
  logic [1:0]                     he;
  logic [1:0]                     mreq;
  logic                           den;
  logic                           oen;
  logic                           arm;
  adr_pkg::adr_diag_t             fmt;

  // Pins and link toggles pass two flops
  adr_sync #(.W(SW)) u_csync (
    .i_clk    (i_ref_clk),
    .i_resetn (i_resetn),
    .i_d      ({lx_r.wr_tgl, lx_r.rd_tgl, i_adsel_code, i_standby_mute_pin,
                i_efficiency_select_pin, i_data_pin, i_fault, i_thermal_warn,
                i_supply_low, i_low_power}),
    .o_q      ({s_wr, s_rd, s_adsel, s_stby, s_eff, s_data, s_fault, s_therm,
                s_slow, s_lowp})
  );

  // Next core state
  always_comb begin
    c_nxt  = c_r;
    rd_ev  = (s_rd != c_r.rseen);
    busdis = (s_adsel == adr_pkg::ADSEL_OPEN);
    // Control source: pins when the bus is off, instruction bytes otherwise
    run = busdis ? (s_stby != 2'h0) : c_r.sib[adr_pkg::SIB_RUN];
    unm = busdis ? {2{s_stby[1]}} : {c_r.fib[adr_pkg::FIB_UMF], c_r.fib[adr_pkg::FIB_UMR]};
    he  = busdis ? {2{s_eff}} : {c_r.sib[adr_pkg::SIB_HE_R], c_r.sib[adr_pkg::SIB_HE_L]};
    den = !busdis && c_r.fib[adr_pkg::FIB_DIAG];
    oen = !busdis && c_r.fib[adr_pkg::FIB_OFFS];
    // Instruction pair taken on the write toggle
    if (s_wr != c_r.wseen) begin
      c_nxt.wseen = s_wr;
      c_nxt.fib   = lx_r.wdat[15:8];
      c_nxt.sib   = lx_r.wdat[7:0];
    end
    // Report format: one short or open fault per channel, highest priority first, offset flag added in the open bit
    for (int k = 0; k < NCH; k++) begin
      fmt[k]                   = 8'h00;
      fmt[k][adr_pkg::DB_DONE] = (c_r.dg == adr_pkg::DG_DONE);
      fmt[k][adr_pkg::DB_PERM] = c_r.perm;
      if (c_r.acc[k].short_gnd) begin
        fmt[k][adr_pkg::DB_SGND] = 1'b1;
      end else if (c_r.acc[k].short_vs) begin
        fmt[k][adr_pkg::DB_SVS] = 1'b1;
      end else if (c_r.acc[k].across) begin
        fmt[k][adr_pkg::DB_ACR] = 1'b1;
      end else if (c_r.acc[k].open_load) begin
        fmt[k][adr_pkg::DB_OPEN] = 1'b1;
      end
      if (c_r.oen && c_r.acc[k].offset) begin
        fmt[k][adr_pkg::DB_OPEN] = 1'b1;
      end
    end
    for (int k = 0; k < adr_pkg::NTW; k++) begin
      fmt[k][adr_pkg::DB_TW] = s_therm[k];
    end
    // A read latches the running results and re-arms every cycle
    arm = rd_ev || (den && !c_r.den) || (oen && !c_r.oen);
    if (rd_ev) begin
      c_nxt.rseen   = s_rd;
      c_nxt.res     = fmt;
      c_nxt.res_tgl = ~c_r.res_tgl;
      if (c_r.dg == adr_pkg::DG_DONE) begin
        c_nxt.perm = 1'b1;
      end
    end
    if (arm) begin
      c_nxt.acc = '1;
      c_nxt.tmr = 23'h0;
      c_nxt.dg  = (den || oen) ? adr_pkg::DG_MEAS : adr_pkg::DG_IDLE;
      if (den && !c_r.den) begin
        c_nxt.perm = 1'b0;
      end
    end else if (!den && !oen) begin
      c_nxt.dg = adr_pkg::DG_IDLE;
    end else begin
      case (c_r.dg)
        adr_pkg::DG_MEAS: begin
          for (int k = 0; k < NCH; k++) begin
            c_nxt.acc[k] = c_r.acc[k] & s_fault[k];
            c_nxt.acc[k].open_load = c_nxt.acc[k].open_load & den & !c_r.perm;
            c_nxt.acc[k].short_gnd = c_nxt.acc[k].short_gnd & den;
            c_nxt.acc[k].short_vs  = c_nxt.acc[k].short_vs & den;
            c_nxt.acc[k].across    = c_nxt.acc[k].across & den;
            c_nxt.acc[k].offset    = c_nxt.acc[k].offset & oen;
          end
          c_nxt.tmr = c_r.tmr + 23'h1;
          if (c_r.tmr == 23'(MEAS_CYC - 1)) begin
            c_nxt.dg = adr_pkg::DG_DONE;
          end
        end
        adr_pkg::DG_DONE: begin
          // Offset window runs on until the stopping read
          for (int k = 0; k < NCH; k++) begin
            c_nxt.acc[k].offset = c_r.acc[k].offset & s_fault[k].offset & oen;
          end
        end
        default: c_nxt.dg = c_r.dg;
      endcase
    end
    c_nxt.den = den;
    c_nxt.oen = oen;
    // Mute transitions, shortened by the fast bit
    mreq = ~unm | {2{~run}};
    if (mreq != c_r.mreq) begin
      c_nxt.mreq = mreq;
      c_nxt.mcnt = (!busdis && c_r.sib[adr_pkg::SIB_FAST]) ? 20'(FMUTE_CYC)
                                                           : 20'(NMUTE_CYC);
    end else if (c_r.mcnt != 20'h0) begin
      c_nxt.mcnt = c_r.mcnt - 20'h1;
      if (c_r.mcnt == 20'h1) begin
        c_nxt.mout = c_r.mreq;
      end
    end
    // Registered controls
    c_nxt.stby   = !run;
    c_nxt.gain   = busdis ? {2{s_data}}
                          : {c_r.fib[adr_pkg::FIB_GF], c_r.fib[adr_pkg::FIB_GR]};
    c_nxt.pair   = he & s_lowp & {2{!s_slow && run}};
    c_nxt.clip   = c_r.fib[adr_pkg::FIB_CLIP];
    c_nxt.supth  = c_r.fib[adr_pkg::FIB_SUPTH];
    c_nxt.busdis = busdis;
  end

  // Core registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c_r      <= '0;
      c_r.fib  <= adr_pkg::IN_RST;
      c_r.sib  <= adr_pkg::IN_RST;
      c_r.mreq <= 2'h3;
      c_r.mout <= 2'h3;
      c_r.stby <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Output drive
  assign o_standby         = c_r.stby;
  assign o_front_mute      = c_r.mout[1];
  assign o_rear_mute       = c_r.mout[0];
  assign o_mute_busy       = (c_r.mcnt != 20'h0);
  assign o_gain_16db       = c_r.gain;
  assign o_bridge_join     = c_r.pair;
  assign o_clip_10pct      = c_r.clip;
  assign o_supply_thr_high = c_r.supth;
  assign o_bus_disabled    = c_r.busdis;
  assign o_diag_result     = c_r.res;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  localparam int FM_CHK = FMUTE_CYC;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_read;
    rd_ev;
  endsequence
  sequence s_rearmed;
    c_r.dg == adr_pkg::DG_MEAS && c_r.tmr == 23'h0;
  endsequence
  property p_rd_snapshot;
    s_read |=> c_r.res == $past(fmt);
  endproperty
  a_rd_snapshot: assert property (p_rd_snapshot) else $error("read result not latched");
  property p_rearm;
    s_read ##0 (den || oen) |=> s_rearmed;
  endproperty
  a_rearm: assert property (p_rearm) else $error("cycle not re-armed on read");
  property p_persist;
    c_r.dg == adr_pkg::DG_MEAS && !arm && !s_fault[0].short_gnd |=> !c_r.acc[0].short_gnd;
  endproperty
  a_persist: assert property (p_persist) else $error("transient fault kept");
  property p_perm_open;
    c_r.dg == adr_pkg::DG_MEAS && c_r.perm && !arm |=> !c_r.acc[1].open_load;
  endproperty
  a_perm_open: assert property (p_perm_open) else $error("open load in permanent");
  property p_prio;
    fmt[2][adr_pkg::DB_SGND] |-> !fmt[2][adr_pkg::DB_SVS] && !fmt[2][adr_pkg::DB_ACR];
  endproperty
  a_prio: assert property (p_prio) else $error("two faults on one channel");
  property p_thermal;
    s_read |=> c_r.res[1][adr_pkg::DB_TW] == $past(s_therm[1]);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal warning lost");
  property p_fast_mute;
    (mreq != c_r.mreq) && !busdis && c_r.sib[adr_pkg::SIB_FAST] |=> c_r.mcnt == 20'(FM_CHK);
  endproperty
  a_fast_mute: assert property (p_fast_mute) else $error("fast mute length wrong");
  property p_supply_join;
    s_slow |=> o_bridge_join == 2'h0;
  endproperty
  a_supply_join: assert property (p_supply_join) else $error("join at low supply");
  property p_pin_mode;
    busdis |=> o_gain_16db == {2{$past(s_data)}} && o_bus_disabled;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin mode gain wrong");
  property p_no_ack_open;
    @(posedge i_link_clk) disable iff (!link_rstn)
      ls_adsel == adr_pkg::ADSEL_OPEN && lk_r.bitc == 4'h7 && lk_r.bytec == 3'h0
      |=> !lk_r.match;
  endproperty
  a_no_ack_open: assert property (p_no_ack_open) else $error("bus answered while off");
endmodule

// ===== tb/adr_host_model.sv
// adr_host_model: host side of the byte link, acting as bus master
// Assumes the device pulls data low through i_sda_oe and a pull-up holds it high
module adr_host_model (
  input  wire logic        i_sda_oe,
  output logic             o_link_clk,
  output logic             o_frame,
  output logic             o_sda,
  output logic             o_rd_valid,
  output logic [31:0]      o_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_low;
  // Open-drain wire: low when either side pulls, else the pull-up wins
  assign o_sda = ~(host_low | i_sda_oe);
  initial begin
    {o_link_clk, o_frame, host_low, o_rd_valid} = 4'h0;
    o_rd_data = 32'h0;
  end
  // One bit slot; link clock only runs inside frames
  task automatic slot(input logic b, output logic s);
    host_low = ~b;
    #16 o_link_clk = 1'b1;
    s = o_sda;
    #16 o_link_clk = 1'b0;
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
    slot(ab, ack);
  endtask
  // Whole frame: address byte then two writes or four reads
  task automatic frame(input logic [6:0] a, input logic rd, input logic [15:0] w,
                       output logic ack);
    logic [7:0] q;
    logic       k;
    o_frame = 1'b1;
    #16 xbyte({a, rd}, 1'b1, q, ack);
    for (int n = 0; n < (rd ? 4 : 2); n++) begin
      xbyte(rd ? 8'hFF : w[15-8*n -: 8], ~rd, q, k);
      if (rd) o_rd_data[8*n +: 8] = q;
    end
    host_low = 1'b0;
    #16 o_frame = 1'b0;
    if (rd) begin
      o_rd_valid = 1'b1;
      #1 o_rd_valid = 1'b0;
    end
    #60;
  endtask
endmodule

// ===== tb/testbench.sv
// testbench: drives the diagnostic report block through the host model
// Assumes shortened counts for measurement and mute times
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                clk, rstn, link_clk, frame, sda, oe, rd_valid;
  logic [1:0]                          adsel, smpin, low_power, gain, pair;
  logic                                eff, dpin, sup_low, stby, fm, rm, busy, bus_dis;
  logic [2:0]                          tw;
  logic [31:0]                         rd_data, diag;
  logic [16:0]                         rnd;
  adr_pkg::adr_fault_t [adr_pkg::NCH-1:0] flt;
  logic [31:0]                         expq[$];
  int                                  failures, checks;
  adr_core #(.MEAS_CYC(50), .FMUTE_CYC(20), .NMUTE_CYC(40)) adr_core_inst (
    .i_ref_clk(clk), .i_resetn(rstn), .i_link_clk(link_clk), .i_link_frame(frame),
    .i_sda_in(sda), .o_sda_out(), .o_sda_oe(oe), .i_adsel_code(adsel),
    .i_standby_mute_pin(smpin), .i_efficiency_select_pin(eff), .i_data_pin(dpin),
    .i_fault(flt), .i_thermal_warn(tw), .i_supply_low(sup_low), .i_low_power(low_power),
    .o_standby(stby), .o_front_mute(fm), .o_rear_mute(rm), .o_mute_busy(busy),
    .o_gain_16db(gain), .o_bridge_join(pair), .o_clip_10pct(), .o_supply_thr_high(),
    .o_bus_disabled(bus_dis), .o_diag_result(diag));
  adr_host_model adr_host_model_inst (.i_sda_oe(oe), .o_link_clk(link_clk), .o_frame(frame),
    .o_sda(sda), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  // Diagnostic word with thermal warnings in D7 of channels 0..2
  function automatic logic [31:0] ex(input logic [7:0] b0, b1, b2, b3);
    return {b3, tw[2], b2[6:0], tw[1], b1[6:0], tw[0], b0[6:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic rd(input logic [31:0] e, input logic ack_exp);
    logic a;
    expq.push_back(e);
    adr_host_model_inst.frame(adr_pkg::ADDR_A, 1'b1, 16'h0, a);
    check({31'h0, a}, {31'h0, ack_exp});
  endtask
  task automatic wr(input logic [7:0] b1, input logic [7:0] b2);
    logic a;
    adr_host_model_inst.frame(adr_pkg::ADDR_A, 1'b0, {b1, b2}, a);
    check({31'h0, a}, 32'h0);
  endtask
  // Read results taken off the queue as they appear
  always @(posedge rd_valid) begin
    if (expq.size() == 0) failures++;
    else check(rd_data, expq.pop_front());
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2ms failures++;
    give_verdict();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {rstn, eff, dpin, sup_low} = 4'h0;
    {adsel, smpin} = 4'h0;
    low_power = 2'h3;
    flt = '0;
    rnd = lfsr(17'h15945);
    tw = rnd[2:0];
    step(12);
    check({stby, fm, rm}, 32'h7);
    rstn = 1'b1;
    step(4);
    // Four distinct faults, one with a lower-priority open load too
    flt[0].short_gnd = 1'b1;
    flt[1].open_load = 1'b1;
    flt[2].short_vs = 1'b1;
    flt[2].open_load = 1'b1;
    flt[3].across = 1'b1;
    wr(8'h56, 8'h33);
    step(30);
    check({stby, fm, rm, gain, pair}, 32'h0B);
    step(60);
    rd(32'h0, 1'b0);
    flt[0] = '0;
    step(60);
    rd(ex(8'h41, 8'h44, 8'h42, 8'h48), 1'b0);
    step(60);
    rd(ex(8'h50, 8'h50, 8'h52, 8'h58), 1'b0);
    sup_low = 1'b1;
    step(6);
    check({30'h0, pair}, 32'h0);
    sup_low = 1'b0;
    low_power = 2'h1;
    step(6);
    check({30'h0, pair}, 32'h1);
    wr(8'h50, 8'h13);
    step(50);
    check({fm, rm, busy}, 32'h6);
    // Offset test: enable opens a window, two reads show the flag
    flt[2].offset = 1'b1;
    wr(8'h70, 8'h13);
    step(60);
    rd(ex(8'h50, 8'h50, 8'h52, 8'h58), 1'b0);
    step(60);
    rd(ex(8'h50, 8'h50, 8'h56, 8'h58), 1'b0);
    adsel = adr_pkg::ADSEL_OPEN;
    {smpin, eff, dpin} = 4'hB;
    low_power = 2'h3;
    step(6);
    check({bus_dis, stby, fm, rm, gain, pair}, 32'hBF);
    rd(32'hFFFFFFFF, 1'b1);
    smpin = 2'h0;
    step(6);
    check({31'h0, stby}, 32'h1);
    give_verdict();
  end
endmodule
